// >>> common/fifo_ctl_map.vh
// Constants for the serializing FIFO controller.
`ifndef FIFO_CTL_MAP_VH
`define FIFO_CTL_MAP_VH
`define CTL_REG_OFS       12'h000
`define STAT_REG_OFS      12'h004
`define PWR_REG_OFS       12'h008
`define PRD_REG_OFS       12'h00C
`define SOUT_REG_OFS      12'h010
`define SIN_REG_OFS       12'h014
`define CTL_DIR_LSB       0
`define CTL_WL_BIT        2
`define CTL_CLR_BIT       3
`define CTL_OE_BIT        4
`define CTL_RESET_VAL     32'h00000008
`define DIR_SER_PAR       2'h0
`define DIR_PAR_SER       2'h1
`define DIR_SER_SER       2'h2
`define STROBE_HALF_NS    100
`define CLK_NS            50
`define STROBE_HALF_CYC   ((`STROBE_HALF_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W             4
`endif

// >>> rtl/fifo_host_ctl.v
// Host controller driving the serializing FIFO pins from APB registers.
`timescale 1ns/1ps
`include "fifo_ctl_map.vh"
module fifo_host_ctl (
    input  wire        clk,
    input  wire        nrst,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         port_direction,
    output reg         serial_through_mode,
    output reg         word_length_select,
    output reg         master_clear_n,
    output reg         parallel_strobe,
    output reg         parallel_drive_enable,
    input  wire [8:0]  parallel_bus_in,
    output reg  [8:0]  parallel_bus_out,
    output reg         parallel_bus_oe,
    input  wire        parallel_ready,
    input  wire        half_level_flag,
    output reg         serial_in_bit,
    output reg         serial_in_strobe,
    input  wire        serial_in_ready_flag,
    input  wire        serial_out_bit,
    output reg         serial_out_strobe,
    input  wire        serial_out_ready_flag
);

// ----------------------------------------------------------------------------
// Pin synchronizers.
// ----------------------------------------------------------------------------
reg  [13:0] sync1_reg;
reg  [13:0] sync2_reg;
wire        pr_s   = sync2_reg[9];
wire        hf_s   = sync2_reg[10];
wire        sir_s  = sync2_reg[11];
wire        sod_s  = sync2_reg[12];
wire        sor_s  = sync2_reg[13];
wire [8:0]  pin_s  = sync2_reg[8:0];

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        sync1_reg <= 14'h0000;
        sync2_reg <= 14'h0000;
    end else if (ce) begin
        sync1_reg <= {serial_out_ready_flag, serial_out_bit, serial_in_ready_flag,
                      half_level_flag, parallel_ready, parallel_bus_in};
        sync2_reg <= sync1_reg;
    end
end

// ----------------------------------------------------------------------------
// Register file.
// ----------------------------------------------------------------------------
reg  [1:0]  dir_reg;
reg         wl_reg;
reg         clr_reg;
reg         oe_reg;
reg  [8:0]  pwr_reg;
reg  [8:0]  prd_reg;
reg  [8:0]  sout_reg;
reg  [8:0]  sin_reg;
reg         pwr_go_reg;
reg         prd_go_reg;
reg         sout_go_reg;
reg         sin_go_reg;
reg         sin_done_reg;
reg         sout_done_reg;
reg         prd_done_reg;
wire        busy = pwr_go_reg | prd_go_reg | sout_go_reg | sin_go_reg;
wire        wr   = psel & penable & pwrite & ce;
wire [3:0]  wlen = wl_reg ? 4'h9 : 4'h8;

// Decodes one register offset for a write.
function wr_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
        wr_hit = (a == ofs);
    end
endfunction

// Forces bit 8 of a word to zero in 8-bit mode.
function [8:0] fit_word;
    input       nine;
    input [8:0] w;
    begin
        fit_word = nine ? w : {1'b0, w[7:0]};
    end
endfunction

wire hit_ctl  = wr & wr_hit(paddr, `CTL_REG_OFS);
wire hit_pwr  = wr & wr_hit(paddr, `PWR_REG_OFS) & ~busy & (dir_reg == `DIR_PAR_SER);
wire hit_prd  = wr & wr_hit(paddr, `PRD_REG_OFS) & ~busy & (dir_reg == `DIR_SER_PAR);
wire hit_sout = wr & wr_hit(paddr, `SOUT_REG_OFS) & ~busy & (dir_reg != `DIR_SER_PAR);
wire hit_sin  = wr & wr_hit(paddr, `SIN_REG_OFS) & ~busy;
// Direction changes only between words and never while the device is full.
wire dir_ok   = ~busy & sir_s;

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        dir_reg <= `DIR_SER_PAR;
        wl_reg  <= 1'b0;
        clr_reg <= 1'b1;
        oe_reg  <= 1'b0;
        pwr_reg <= 9'h000;
    end else if (hit_ctl) begin
        if (dir_ok || pwdata[1:0] == dir_reg) begin
            dir_reg <= (pwdata[1:0] == 2'h3) ? `DIR_SER_SER : pwdata[1:0];
        end
        wl_reg  <= pwdata[`CTL_WL_BIT];
        clr_reg <= pwdata[`CTL_CLR_BIT];
        oe_reg  <= pwdata[`CTL_OE_BIT];
    end else if (hit_pwr) begin
        pwr_reg <= fit_word(wl_reg, pwdata[8:0]);
    end
end

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        prdata  <= 32'h00000000;
        pready  <= 1'b0;
        pslverr <= 1'b0;
    end else if (ce) begin
        pready  <= psel & ~penable;
        pslverr <= psel & ~penable & (paddr > `SIN_REG_OFS);
        case (paddr)
            `CTL_REG_OFS:  prdata <= {27'h0, oe_reg, clr_reg, wl_reg, dir_reg};
            `STAT_REG_OFS: prdata <= {22'h0, sout_done_reg, sin_done_reg, prd_done_reg, busy,
                                      sor_s, sir_s, hf_s, pr_s, 2'h0};
            `PWR_REG_OFS:  prdata <= {23'h0, pwr_reg};
            `PRD_REG_OFS:  prdata <= {23'h0, prd_reg};
            `SOUT_REG_OFS: prdata <= {23'h0, sout_reg};
            `SIN_REG_OFS:  prdata <= {23'h0, sin_reg};
            default:       prdata <= 32'h00000000;
        endcase
    end
end

// ----------------------------------------------------------------------------
// Device control pins.
// ----------------------------------------------------------------------------
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        port_direction        <= 1'b0;
        serial_through_mode   <= 1'b0;
        word_length_select    <= 1'b0;
        master_clear_n        <= 1'b0;
        parallel_drive_enable <= 1'b0;
        parallel_bus_out      <= 9'h000;
        parallel_bus_oe       <= 1'b0;
    end else if (ce) begin
        port_direction        <= (dir_reg == `DIR_PAR_SER);
        serial_through_mode   <= (dir_reg == `DIR_SER_SER);
        word_length_select    <= wl_reg;
        master_clear_n        <= ~clr_reg;
        parallel_drive_enable <= oe_reg & (dir_reg == `DIR_SER_PAR);
        parallel_bus_out      <= pwr_reg;
        parallel_bus_oe       <= (dir_reg == `DIR_PAR_SER);
    end
end

// ----------------------------------------------------------------------------
// Pin sequencer.
// ----------------------------------------------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_WAIT = 3'h1;
localparam ST_HIGH = 3'h2;
localparam ST_LOW  = 3'h3;
localparam ST_DONE = 3'h4;

reg [2:0]        st_reg;
reg [`CNT_W-1:0] tmr_reg;
reg [3:0]        bit_reg;
wire             tmr_end = (tmr_reg == `CNT_W'd0);
// Strobe phase length in clock cycles, cut to the timer width.
wire [31:0]      half_cyc = `STROBE_HALF_CYC;
wire [`CNT_W-1:0] tmr_load = half_cyc[`CNT_W-1:0];

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        st_reg                <= ST_IDLE;
        tmr_reg               <= {`CNT_W{1'b0}};
        bit_reg               <= 4'h0;
        pwr_go_reg            <= 1'b0;
        prd_go_reg            <= 1'b0;
        sout_go_reg           <= 1'b0;
        sin_go_reg            <= 1'b0;
        sin_done_reg          <= 1'b0;
        sout_done_reg         <= 1'b0;
        prd_done_reg          <= 1'b0;
        prd_reg               <= 9'h000;
        sout_reg              <= 9'h000;
        sin_reg               <= 9'h000;
        parallel_strobe       <= 1'b0;
        serial_in_strobe      <= 1'b0;
        serial_out_strobe     <= 1'b0;
        serial_in_bit         <= 1'b0;
    end else if (ce) begin
        if (!tmr_end) begin
            tmr_reg <= tmr_reg - `CNT_W'd1;
        end
        if (hit_pwr) begin
            pwr_go_reg <= 1'b1;
        end
        if (hit_prd) begin
            prd_go_reg   <= 1'b1;
            prd_done_reg <= 1'b0;
        end
        if (hit_sout) begin
            sout_go_reg   <= 1'b1;
            sout_done_reg <= 1'b0;
            sout_reg      <= 9'h000;
            bit_reg       <= 4'h0;
        end
        if (hit_sin) begin
            sin_go_reg   <= 1'b1;
            sin_done_reg <= 1'b0;
            sin_reg      <= fit_word(wl_reg, pwdata[8:0]);
            bit_reg      <= 4'h0;
        end
        case (st_reg)
            ST_IDLE: begin
                if (busy && clr_reg == 1'b0) begin
                    st_reg <= ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Parallel ready and serial flags are status; wait for them before a strobe.
                if ((pwr_go_reg && pr_s) || (prd_go_reg && pr_s)) begin
                    prd_reg         <= pin_s;
                    parallel_strobe <= 1'b1;
                    tmr_reg         <= tmr_load;
                    st_reg          <= ST_HIGH;
                end else if (sin_go_reg && sir_s) begin
                    serial_in_bit    <= sin_reg[bit_reg];
                    tmr_reg          <= tmr_load;
                    st_reg           <= ST_LOW;
                end else if (sout_go_reg && sor_s) begin
                    serial_out_strobe <= 1'b1;
                    tmr_reg           <= tmr_load;
                    st_reg            <= ST_HIGH;
                end
            end
            ST_LOW: begin
                // Data set up, then rising edge of the serial input strobe.
                if (tmr_end) begin
                    serial_in_strobe <= 1'b1;
                    tmr_reg          <= tmr_load;
                    st_reg           <= ST_HIGH;
                end
            end
            ST_HIGH: begin
                // Parallel ready stays low while the strobe is high.
                if (tmr_end) begin
                    if (parallel_strobe) begin
                        parallel_strobe <= 1'b0;
                        st_reg          <= ST_DONE;
                    end else begin
                        serial_in_strobe  <= 1'b0;
                        serial_out_strobe <= 1'b0;
                        if (serial_out_strobe) begin
                            sout_reg[bit_reg] <= sod_s;
                        end
                        tmr_reg <= tmr_load;
                        st_reg  <= ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                if (tmr_end) begin
                    if (pwr_go_reg || prd_go_reg) begin
                        prd_done_reg <= prd_go_reg;
                        pwr_go_reg   <= 1'b0;
                        prd_go_reg   <= 1'b0;
                        st_reg       <= ST_IDLE;
                    end else if (bit_reg == wlen - 4'h1) begin
                        sin_done_reg  <= sin_go_reg;
                        sout_done_reg <= sout_go_reg;
                        sin_go_reg    <= 1'b0;
                        sout_go_reg   <= 1'b0;
                        st_reg        <= ST_IDLE;
                    end else begin
                        bit_reg <= bit_reg + 4'h1;
                        st_reg  <= ST_WAIT;
                    end
                end
            end
            default: begin
                st_reg <= ST_IDLE;
            end
        endcase
    end
end

endmodule // fifo_host_ctl

// >>> verif/fifo_host_ctl_asserts.sv
// Checker for the pin sequencing of the FIFO host controller.
`timescale 1ns/1ps
module fifo_host_ctl_asserts (
    input logic       clk,
    input logic       nrst,
    input logic       port_direction,
    input logic       serial_through_mode,
    input logic       word_length_select,
    input logic       parallel_strobe,
    input logic [8:0] parallel_bus_out,
    input logic       parallel_bus_oe,
    input logic       serial_in_strobe,
    input logic       serial_out_strobe,
    input logic       serial_in_ready_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_load_drives;
        parallel_strobe && port_direction && !serial_through_mode |-> parallel_bus_oe;
    endproperty
    a_load_drives: assert property (p_load_drives) else $error("Load strobe without bus drive.");
    property p_load_hold;
        parallel_strobe && parallel_bus_oe ##1 parallel_strobe |-> $stable(parallel_bus_out);
    endproperty
    a_load_hold: assert property (p_load_hold) else $error("Load data moved under strobe.");
    property p_strobe_width;
        $rose(parallel_strobe) |-> parallel_strobe[*3] ##1 !parallel_strobe;
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("Parallel strobe width wrong.");
    property p_full_hold;
        !serial_in_ready_flag[*4] |=> $stable(port_direction);
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("Direction changed while full.");
    property p_word_hold;
        serial_in_strobe || serial_out_strobe || parallel_strobe |=> $stable(port_direction);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("Direction changed inside a word.");
    c_load: cover property ($rose(parallel_strobe) && port_direction);
    c_full: cover property ($fell(serial_in_ready_flag));
    c_sout: cover property ($rose(serial_out_strobe) && word_length_select);
endmodule // fifo_host_ctl_asserts

bind fifo_host_ctl fifo_host_ctl_asserts u_chk (.clk(clk), .nrst(nrst), .port_direction(port_direction),
    .serial_through_mode(serial_through_mode), .word_length_select(word_length_select),
    .parallel_strobe(parallel_strobe), .parallel_bus_out(parallel_bus_out), .parallel_bus_oe(parallel_bus_oe),
    .serial_in_strobe(serial_in_strobe), .serial_out_strobe(serial_out_strobe),
    .serial_in_ready_flag(serial_in_ready_flag));

// >>> verif/fifo_dev_model.sv
// Behavioural model of the serializing FIFO device.
`timescale 1ns/1ps
module fifo_dev_model (
    input  logic       port_direction,
    input  logic       serial_through_mode,
    input  logic       word_length_select,
    input  logic       master_clear_n,
    input  logic       parallel_strobe,
    input  logic       parallel_drive_enable,
    input  logic [8:0] parallel_bus_out,
    input  logic       parallel_bus_oe,
    input  logic       serial_in_bit,
    input  logic       serial_in_strobe,
    input  logic       serial_out_strobe,
    output logic [8:0] parallel_bus_in,
    output logic       parallel_ready,
    output logic       half_level_flag,
    output logic       serial_in_ready_flag,
    output logic       serial_out_bit,
    output logic       serial_out_ready_flag
);
    logic [8:0] mem[$];
    logic [8:0] hd = 9'h000;
    logic [8:0] input_stager = 9'h000;
    logic       obit = 1'h0;
    int         cnt = 0;
    int         ib = 0;
    int         ob = 0;
    wire  [8:0] msk = word_length_select ? 9'h1FF : 9'h0FF;
    wire  [3:0] nb = word_length_select ? 4'h9 : 4'h8;
    wire        par_in = port_direction && !serial_through_mode;
    wire        par_out = !port_direction && !serial_through_mode;
    wire        sout_on = port_direction || serial_through_mode;
    task automatic upd();
        cnt = mem.size();
        hd = (cnt > 0) ? mem[0] : 9'h000;
    endtask
    always @(negedge master_clear_n) begin
        mem.delete();
        input_stager = 9'h000;
        ib = 0;
        ob = 0;
        upd();
    end
    always @(port_direction or serial_through_mode) if (ib != 0 && cnt < 64) begin
        mem.push_back(input_stager & msk);
        input_stager = 9'h000;
        ib = 0;
        upd();
    end
    always @(posedge parallel_strobe) if (par_in && master_clear_n && cnt < 64) begin
        mem.push_back((parallel_bus_oe ? parallel_bus_out : 9'h1AA) & msk);
        upd();
    end
    always @(negedge parallel_strobe) if (par_out && cnt > 0) begin
        void'(mem.pop_front());
        upd();
    end
    always @(posedge serial_in_strobe) if (master_clear_n && cnt < 64) begin
        input_stager[ib] = serial_in_bit;
        ib++;
        if (ib == nb) begin
            mem.push_back(input_stager & msk);
            input_stager = 9'h000;
            ib = 0;
            upd();
        end
    end
    always @(posedge serial_out_strobe) if (master_clear_n && sout_on && cnt > 0) begin
        obit = hd[ob];
        ob++;
        if (ob == nb) begin
            void'(mem.pop_front());
            ob = 0;
            upd();
        end
    end
    assign parallel_ready = master_clear_n && !serial_through_mode && !parallel_strobe
                            && (port_direction ? cnt < 64 : cnt > 0);
    assign half_level_flag = master_clear_n && (cnt - ((ob != 0) ? 1 : 0)) >= 32;
    assign serial_in_ready_flag = master_clear_n && cnt < 64;
    assign serial_out_ready_flag = master_clear_n && sout_on && cnt > 0;
    assign serial_out_bit = (master_clear_n && sout_on) ? obit : ~obit;
    assign parallel_bus_in = (par_out && parallel_drive_enable && cnt > 0) ? hd : ~hd;
endmodule // fifo_dev_model

// >>> verif/testbench.sv
// Self-checking bench for the FIFO host controller against the device model.
`timescale 1ns/1ps
module testbench;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0]  parallel_bus_in, parallel_bus_out;
    logic        port_direction, serial_through_mode, word_length_select, master_clear_n, parallel_strobe;
    logic        parallel_drive_enable, parallel_bus_oe, parallel_ready, half_level_flag, serial_in_bit;
    logic        serial_in_strobe, serial_in_ready_flag, serial_out_bit, serial_out_strobe, serial_out_ready_flag;
    int          error_cnt = 0;
    int          total_checks = 0;
    fifo_host_ctl uut (.clk, .nrst, .ce(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .port_direction, .serial_through_mode, .word_length_select, .master_clear_n, .parallel_strobe,
        .parallel_drive_enable, .parallel_bus_in, .parallel_bus_out, .parallel_bus_oe, .parallel_ready,
        .half_level_flag, .serial_in_bit, .serial_in_strobe, .serial_in_ready_flag, .serial_out_bit,
        .serial_out_strobe, .serial_out_ready_flag);
    fifo_dev_model dev (.port_direction, .serial_through_mode, .word_length_select, .master_clear_n,
        .parallel_strobe, .parallel_drive_enable, .parallel_bus_out, .parallel_bus_oe, .serial_in_bit,
        .serial_in_strobe, .serial_out_strobe, .parallel_bus_in, .parallel_ready, .half_level_flag,
        .serial_in_ready_flag, .serial_out_bit, .serial_out_ready_flag);
    task automatic tally_and_finish();
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (pready !== 1'h1) begin
            error_cnt++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic op(input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        apb(1'h1, a, d);
        do begin
            apb(1'h0, 12'h004, 32'h0);
            k++;
        end while ((rd[6] !== 1'h0 || k < 2) && k < 400);
        if (rd[6] !== 1'h0) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    // ----
    // Scenarios.
    // ----
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial begin
        nrst = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        nrst <= 1'h1;
        apb(1'h0, 12'h000, 32'h0);
        check(rd, 32'h00000008);
        op(12'h000, 32'h00000000);
        check(rd & 32'h0000001C, 32'h00000010);
        op(12'h000, 32'h00000001);
        op(12'h008, 32'h000001A5);
        op(12'h010, 32'h0);
        apb(1'h0, 12'h010, 32'h0);
        check(rd & 32'h000001FF, 32'h000000A5);
        op(12'h000, 32'h00000005);
        op(12'h008, 32'h000001A5);
        op(12'h010, 32'h0);
        apb(1'h0, 12'h010, 32'h0);
        check(rd & 32'h000001FF, 32'h000001A5);
        op(12'h000, 32'h00000010);
        op(12'h014, 32'h000001C3);
        op(12'h00C, 32'h0);
        apb(1'h0, 12'h00C, 32'h0);
        check(rd & 32'h000001FF, 32'h000000C3);
        op(12'h000, 32'h00000012);
        op(12'h014, 32'h0000005A);
        op(12'h010, 32'h0);
        apb(1'h0, 12'h010, 32'h0);
        check(rd & 32'h000001FF, 32'h0000005A);
        op(12'h000, 32'h00000001);
        for (int i = 0; i < 64; i++) begin
            op(12'h008, 32'h00000040 + i);
            if (i == 30 || i == 31)
                check(rd & 32'h00000008, (i == 31) ? 32'h00000008 : 32'h0);
        end
        check(rd & 32'h00000014, 32'h0);
        op(12'h000, 32'h00000000);
        apb(1'h0, 12'h000, 32'h0);
        check(rd & 32'h00000003, 32'h00000001);
        op(12'h010, 32'h0);
        check(rd & 32'h00000018, 32'h00000018);
        apb(1'h0, 12'h010, 32'h0);
        check(rd & 32'h000001FF, 32'h00000040);
        op(12'h000, 32'h00000009);
        check(rd & 32'h0000001C, 32'h0);
        apb(1'h0, 12'h018, 32'h0);
        check({31'h0, er}, 32'h00000001);
        tally_and_finish();
    end
endmodule // testbench
